// *** hw/spg_pkg.sv ***
// Constants, register map and carrier types of the sync pulse generator
// Operation
// - Mode 00: horizontal free-run, period from 10-bit value
// - Mode 01: follow horizontal input, insert missing pulses
// - Mode 11: follow horizontal input, no insertion
// - Free horizontal width is code plus two clocks
// - Vertical mode 00: period is count times lines
// - Vertical mode 01: follow input, insert missing pulses
// - Vertical mode 11: follow input, no insertion
// - Free vertical width is code plus two lines
// - Internal generators produce active-high pulses
// - Output stage applies polarity selection to the sync and clamp outputs
// - Clamp enable gives clamp with every horizontal pulse
// - Clamp starts after front or back porch
// - Clamp width is four times code plus five
// - Pattern only when enabled and free-running
// - Suspend bit disables the H/V generators and pattern; the clamp only freezes in its state
// - Vertical flag edge: 0 rising, 1 falling
// - Input selects: pins or green/separated sources
// - Output polarity bit: 0 positive, 1 negative
// - Pattern: white, hatch, black, inverse hatch
// - Clamp polarity; disabled output holds static level
package spg_pkg;

  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam int REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_DETECT_CONTROL = 8'hf1;
  localparam logic [7:0] IDX_MODE_DETECT_FLAGS = 8'hf2;
  localparam logic [7:0] IDX_HVGEN = 8'hf9;
  localparam logic [7:0] IDX_CPGEN = 8'hfa;
  localparam logic [7:0] IDX_VFH = 8'hfb;
  localparam logic [7:0] IDX_VFL = 8'hfc;
  localparam logic [7:0] IDX_HFH = 8'hfd;
  localparam logic [7:0] IDX_HFL = 8'hfe;
  localparam logic [1:0] ADDR_LSBS = 2'h0;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // mode_detect_control fields
  localparam int MODE_DETECT_CONTROL_SUSPEND = 7;
  localparam int MODE_DETECT_CONTROL_CLAMP_EN = 6;
  localparam int MODE_DETECT_CONTROL_PAT_EN = 5;
  localparam int MODE_DETECT_CONTROL_VIRQ_EDGE = 2;
  localparam int MODE_DETECT_CONTROL_HSEL = 1;
  localparam int MODE_DETECT_CONTROL_V_INPUT_SELECT = 0;
  localparam logic [REG_W-1:0] MODE_DETECT_CONTROL_MASK = 8'he7;
  // Generation control fields
  localparam int HVGEN_H_IN_POLARITY = 6;
  localparam int HVGEN_HMODE = 4;
  localparam int HVGEN_V_IN_POLARITY = 2;
  localparam int HVGEN_VMODE = 0;
  localparam logic [REG_W-1:0] HVGEN_MASK = 8'h77;
  // Clamp and pattern control fields
  localparam int CPGEN_CLAMP_POLARITY = 7;
  localparam int CPGEN_CFB = 6;
  localparam int CPGEN_CPW = 3;
  localparam int CPGEN_PATTERN_SELECT = 0;
  localparam logic [REG_W-1:0] CPGEN_MASK = 8'hfb;
  localparam logic [REG_W-1:0] HFL_MASK = 8'hdf;
  localparam int MODE_DETECT_FLAGS_VIRQ = 6;

  // Generator modes
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_INSERT = 2'h1;
  localparam logic [1:0] MODE_FOLLOW = 2'h3;
  // Patterns
  localparam logic [1:0] PAT_WHITE = 2'h0;
  localparam logic [1:0] PAT_HATCH = 2'h1;
  localparam logic [1:0] PAT_BLACK = 2'h2;
  localparam logic [1:0] PAT_INV_HATCH = 2'h3;
  localparam int PAT_GRID_BITS = 4;

  // Width laws
  localparam logic [5:0] H_WIDTH_BIAS = 6'h02;
  localparam logic [4:0] V_WIDTH_BIAS = 5'h02;
  localparam logic [5:0] CLAMP_BIAS = 6'h05;

  // Generator timebase: 12 MHz enable derived from 250 MHz by accumulation
  localparam int REF_CLK_KHZ = 250000;
  localparam int GEN_CLK_KHZ = 12000;
  localparam logic [17:0] ACC_STEP = 18'(GEN_CLK_KHZ);
  localparam logic [17:0] ACC_MOD = 18'(REF_CLK_KHZ);

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
  } spg_apb_req_t;

  typedef struct packed {
    logic [APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } spg_apb_rsp_t;

  // Flags from the measurement side, shown in mode_detect_flags
  typedef struct packed {
    logic h_present;
    logic v_present;
    logic h_in_polarity;
    logic v_in_polarity;
    logic h_change_flag;
    logic v_change_flag;
  } spg_meas_t;

  typedef struct packed {
    logic h_sync_output;
    logic v_sync_output;
    logic clamp_output;
    logic pattern_output;
  } spg_sync_out_t;

endpackage : spg_pkg

// *** hw/spg_sync_gen.sv ***
// Sync pulse generator: APB registers, H/V generators, clamp and pattern
`timescale 1ns/1ps
module spg_sync_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire spg_pkg::spg_apb_req_t apb_req,
  output spg_pkg::spg_apb_rsp_t apb_rsp,
  input wire logic h_sync_input,
  input wire logic v_sync_input,
  input wire logic green_sync_input,
  input wire logic sep_v_sync_input,
  input wire spg_pkg::spg_meas_t meas,
  output logic v_irq_flag,
  output spg_pkg::spg_sync_out_t sync_out
);
  import spg_pkg::*;

  typedef enum logic {CL_IDLE, CL_PULSE} spg_clamp_state_t;

  logic [REG_W-1:0] mode_detect_control;
  logic [REG_W-1:0] hv_gen_control;
  logic [REG_W-1:0] clamp_pat_control;
  logic [REG_W-1:0] v_free_hi;
  logic [REG_W-1:0] v_free_lo;
  logic [REG_W-1:0] h_free_hi;
  logic [REG_W-1:0] h_free_lo;
  logic [APB_DATA_W-1:0] prdata;
  logic [17:0] gen_acc;
  logic tick;
  logic h_sel_prev;
  logic v_sel_prev;
  logic [9:0] hf_cnt;
  logic [9:0] hw_cnt;
  logic h_ins;
  logic [11:0] vf_cnt;
  logic [11:0] vw_cnt;
  logic v_ins;
  logic h_int_prev;
  logic [5:0] clamp_cnt;
  spg_clamp_state_t clamp_state;

  // Field views
  wire sync_suspend = mode_detect_control[MODE_DETECT_CONTROL_SUSPEND];
  wire clamp_enable = mode_detect_control[MODE_DETECT_CONTROL_CLAMP_EN];
  wire pattern_enable = mode_detect_control[MODE_DETECT_CONTROL_PAT_EN];
  wire v_irq_edge_select = mode_detect_control[MODE_DETECT_CONTROL_VIRQ_EDGE];
  wire h_input_select = mode_detect_control[MODE_DETECT_CONTROL_HSEL];
  wire v_input_select = mode_detect_control[MODE_DETECT_CONTROL_V_INPUT_SELECT];
  wire h_out_polarity = hv_gen_control[HVGEN_H_IN_POLARITY];
  wire v_out_polarity = hv_gen_control[HVGEN_V_IN_POLARITY];
  wire [1:0] h_gen_mode = hv_gen_control[HVGEN_HMODE +: 2];
  wire [1:0] v_gen_mode = hv_gen_control[HVGEN_VMODE +: 2];
  wire clamp_polarity = clamp_pat_control[CPGEN_CLAMP_POLARITY];
  wire clamp_porch_select = clamp_pat_control[CPGEN_CFB];
  wire [2:0] clamp_width = clamp_pat_control[CPGEN_CPW +: 3];
  wire [1:0] pattern_select = clamp_pat_control[CPGEN_PATTERN_SELECT +: 2];
  wire [9:0] h_free_period = {h_free_hi, h_free_lo[7:6]};
  wire [4:0] h_out_width = h_free_lo[4:0];
  wire [11:0] v_free_count = {v_free_hi, v_free_lo[7:4]};
  wire [3:0] v_out_width = v_free_lo[3:0];

  // APB decode; zero wait states, so read data is captured in the setup cycle
  // Index bits above the byte must be zero, or aliases would decode
  wire [APB_ADDR_W-3:0] idx_full = apb_req.paddr[APB_ADDR_W-1:2];
  wire [7:0] reg_idx = idx_full[7:0];
  wire idx_hi_ok = (idx_full[APB_ADDR_W-3:8] == '0);
  wire addr_ok = (apb_req.paddr[1:0] == ADDR_LSBS) && idx_hi_ok && (reg_idx == IDX_MODE_DETECT_CONTROL ||
    reg_idx == IDX_MODE_DETECT_FLAGS || reg_idx == IDX_HVGEN || reg_idx == IDX_CPGEN ||
    reg_idx == IDX_VFH || reg_idx == IDX_VFL || reg_idx == IDX_HFH || reg_idx == IDX_HFL);
  wire setup = apb_req.psel && !apb_req.penable;
  wire access = apb_req.psel && apb_req.penable;
  wire wr_en = access && apb_req.pwrite && addr_ok;
  wire [REG_W-1:0] wdata = apb_req.pwdata[REG_W-1:0];

  logic [REG_W-1:0] rd_mux;
  always_comb begin
    case (reg_idx)
      IDX_MODE_DETECT_CONTROL: rd_mux = mode_detect_control;
      IDX_MODE_DETECT_FLAGS: rd_mux = {1'b0, v_irq_flag, meas.h_present, meas.v_present,
        meas.h_in_polarity, meas.v_in_polarity, meas.h_change_flag, meas.v_change_flag};
      IDX_HVGEN: rd_mux = hv_gen_control;
      IDX_CPGEN: rd_mux = clamp_pat_control;
      IDX_VFH: rd_mux = v_free_hi;
      IDX_VFL: rd_mux = v_free_lo;
      IDX_HFH: rd_mux = h_free_hi;
      IDX_HFL: rd_mux = h_free_lo;
      default: rd_mux = REG_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= (addr_ok && !apb_req.pwrite) ? {24'h000000, rd_mux} : '0;
    end
  end

  assign apb_rsp.prdata = prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access && !addr_ok;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_detect_control <= REG_RESET;
      hv_gen_control <= REG_RESET;
      clamp_pat_control <= REG_RESET;
      v_free_hi <= REG_RESET;
      v_free_lo <= REG_RESET;
      h_free_hi <= REG_RESET;
      h_free_lo <= REG_RESET;
    end else if (wr_en) begin
      case (reg_idx)
        IDX_MODE_DETECT_CONTROL: mode_detect_control <= wdata & MODE_DETECT_CONTROL_MASK;
        IDX_HVGEN: hv_gen_control <= wdata & HVGEN_MASK;
        IDX_CPGEN: clamp_pat_control <= wdata & CPGEN_MASK;
        IDX_VFH: v_free_hi <= wdata;
        IDX_VFL: v_free_lo <= wdata;
        IDX_HFH: h_free_hi <= wdata;
        IDX_HFL: h_free_lo <= wdata & HFL_MASK;
        default: ;
      endcase
    end
  end

  // 12 MHz generator enable; fractional so the average rate is exact
  wire [17:0] acc_sum = gen_acc + ACC_STEP;
  always_ff @(posedge ref_clk) begin
    if (rst || sync_suspend) begin
      gen_acc <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (acc_sum >= ACC_MOD);
      gen_acc <= (acc_sum >= ACC_MOD) ? acc_sum - ACC_MOD : acc_sum;
    end
  end

  // Input selection and edge detection at the generator rate
  wire h_sel = h_input_select ? green_sync_input : h_sync_input;
  wire v_sel = v_input_select ? sep_v_sync_input : v_sync_input;
  wire h_rise = tick && h_sel && !h_sel_prev;
  wire v_rise = tick && v_sel && !v_sel_prev;
  wire v_fall = tick && !v_sel && v_sel_prev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      h_sel_prev <= 1'b0;
      v_sel_prev <= 1'b0;
    end else if (tick) begin
      h_sel_prev <= h_sel;
      v_sel_prev <= v_sel;
    end
  end

  // Vertical flag; a new edge wins over a write-one clear in the same cycle
  wire v_irq_event = v_irq_edge_select ? v_fall : v_rise;
  wire v_irq_clear = wr_en && reg_idx == IDX_MODE_DETECT_FLAGS && wdata[MODE_DETECT_FLAGS_VIRQ];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      v_irq_flag <= 1'b0;
    end else if (v_irq_event) begin
      v_irq_flag <= 1'b1;
    end else if (v_irq_clear) begin
      v_irq_flag <= 1'b0;
    end
  end

  // Free-running horizontal timebase; a zero period is treated as one clock
  wire [9:0] h_last = (h_free_period == '0) ? '0 : h_free_period - 10'h001;
  wire hf_wrap = tick && (hf_cnt == h_last);
  always_ff @(posedge ref_clk) begin
    if (rst || sync_suspend) begin
      hf_cnt <= '0;
    end else if (tick) begin
      hf_cnt <= (hf_cnt == h_last) ? '0 : hf_cnt + 10'h001;
    end
  end

  // Horizontal watchdog: restarted by input edges, inserts on timeout
  always_ff @(posedge ref_clk) begin
    if (rst || sync_suspend) begin
      hw_cnt <= '0;
      h_ins <= 1'b0;
    end else if (h_rise) begin
      hw_cnt <= '0;
      h_ins <= 1'b0;
    end else if (tick) begin
      hw_cnt <= (hw_cnt == h_last) ? '0 : hw_cnt + 10'h001;
      if (hw_cnt == h_last) begin
        h_ins <= 1'b1;
      end
    end
  end

  wire [5:0] h_width = {1'b0, h_out_width} + H_WIDTH_BIAS;
  wire h_free_pulse = {2'b00, hf_cnt} < {4'h0, h_width};
  wire h_ins_pulse = h_ins && ({2'b00, hw_cnt} < {4'h0, h_width});
  logic h_int;
  always_comb begin
    case (h_gen_mode)
      MODE_FREE: h_int = h_free_pulse;
      MODE_INSERT: h_int = h_sel || h_ins_pulse;
      MODE_FOLLOW: h_int = h_sel;
      default: h_int = 1'b0;
    endcase
    if (sync_suspend) begin
      h_int = 1'b0;
    end
  end

  // Vertical timebase counts free-running lines
  wire [11:0] v_last = (v_free_count == '0) ? '0 : v_free_count - 12'h001;
  always_ff @(posedge ref_clk) begin
    if (rst || sync_suspend) begin
      vf_cnt <= '0;
    end else if (hf_wrap) begin
      vf_cnt <= (vf_cnt == v_last) ? '0 : vf_cnt + 12'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || sync_suspend) begin
      vw_cnt <= '0;
      v_ins <= 1'b0;
    end else if (v_rise) begin
      vw_cnt <= '0;
      v_ins <= 1'b0;
    end else if (hf_wrap) begin
      vw_cnt <= (vw_cnt == v_last) ? '0 : vw_cnt + 12'h001;
      if (vw_cnt == v_last) begin
        v_ins <= 1'b1;
      end
    end
  end

  wire [4:0] v_width = {1'b0, v_out_width} + V_WIDTH_BIAS;
  wire v_free_pulse = vf_cnt < {7'h00, v_width};
  wire v_ins_pulse = v_ins && (vw_cnt < {7'h00, v_width});
  logic v_int;
  always_comb begin
    case (v_gen_mode)
      MODE_FREE: v_int = v_free_pulse;
      MODE_INSERT: v_int = v_sel || v_ins_pulse;
      MODE_FOLLOW: v_int = v_sel;
      default: v_int = 1'b0;
    endcase
    if (sync_suspend) begin
      v_int = 1'b0;
    end
  end

  // Clamp: front porch ends at the pulse lead, back porch at its trail
  wire h_lead = tick && h_int && !h_int_prev;
  wire h_trail = tick && !h_int && h_int_prev;
  wire clamp_start = clamp_enable && (clamp_porch_select ? h_trail : h_lead);
  wire [5:0] clamp_len = {1'b0, clamp_width, 2'b00} + CLAMP_BIAS;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      h_int_prev <= 1'b0;
    end else if (tick) begin
      h_int_prev <= h_int;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !clamp_enable) begin
      clamp_state <= CL_IDLE;
      clamp_cnt <= '0;
    end else begin
      case (clamp_state)
        CL_IDLE: begin
          if (clamp_start) begin
            clamp_state <= CL_PULSE;
            clamp_cnt <= clamp_len;
          end
        end
        CL_PULSE: begin
          if (tick) begin
            clamp_cnt <= clamp_cnt - 6'h01;
            if (clamp_cnt == 6'h01) begin
              clamp_state <= CL_IDLE;
            end
          end
        end
        default: clamp_state <= CL_IDLE;
      endcase
    end
  end

  // Pattern: grid lines from the free-running counters
  wire hatch = (hf_cnt[PAT_GRID_BITS-1:0] == '0) || (vf_cnt[PAT_GRID_BITS-1:0] == '0);
  logic pat_pix;
  always_comb begin
    case (pattern_select)
      PAT_WHITE: pat_pix = 1'b1;
      PAT_HATCH: pat_pix = hatch;
      PAT_BLACK: pat_pix = 1'b0;
      PAT_INV_HATCH: pat_pix = !hatch;
      default: pat_pix = 1'b0;
    endcase
  end
  wire pat_on = pattern_enable && h_gen_mode == MODE_FREE && v_gen_mode == MODE_FREE &&
    !sync_suspend;

  // Registered output stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      sync_out.h_sync_output <= h_int ^ h_out_polarity;
      sync_out.v_sync_output <= v_int ^ v_out_polarity;
      sync_out.clamp_output <= (clamp_state == CL_PULSE) ^ clamp_polarity;
      sync_out.pattern_output <= pat_on && pat_pix;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_h_timeout;
    tick && !h_rise && h_gen_mode == MODE_INSERT && hw_cnt == h_last && !sync_suspend;
  endsequence
  sequence s_clamp_go;
    clamp_state == CL_IDLE && clamp_start;
  endsequence

  a_h_free_wrap: assert property (hf_wrap && !sync_suspend |=> hf_cnt == '0)
    else $error("free horizontal counter did not wrap at period");
  a_h_insert_pulse: assert property (s_h_timeout ##1 !h_rise[*1] |-> h_ins)
    else $error("missing horizontal pulse not flagged for insertion");
  a_h_follow_copy: assert property (h_gen_mode == MODE_FOLLOW && !sync_suspend
    |=> sync_out.h_sync_output == $past(h_sel ^ h_out_polarity))
    else $error("follow mode output differs from input");
  a_h_free_width: assert property (h_gen_mode == MODE_FREE && !sync_suspend &&
    hf_cnt <= {5'h00, h_out_width} + 10'h001 |-> h_int)
    else $error("free horizontal pulse too short");
  a_v_free_width: assert property (v_gen_mode == MODE_FREE && !sync_suspend &&
    vf_cnt > {8'h00, v_out_width} + 12'h001 |-> !v_int)
    else $error("free vertical pulse too long");
  a_clamp_len: assert property (s_clamp_go |=> clamp_cnt == {1'b0, $past(clamp_width), 2'b00}
    + CLAMP_BIAS)
    else $error("clamp width not loaded as four times code plus five");
  a_clamp_static: assert property (!clamp_enable ##1 !clamp_enable
    |=> sync_out.clamp_output == $past(clamp_polarity))
    else $error("disabled clamp output not static");
  a_pattern_gate: assert property (h_gen_mode != MODE_FREE || !pattern_enable
    |=> !sync_out.pattern_output)
    else $error("pattern active outside free running");
  // Tick is a flop, so one last tick may trail the suspend write
  a_suspend_quiet: assert property (sync_suspend |->
    !h_int && !v_int && (!tick || !$past(sync_suspend)))
    else $error("generator active while suspended");
  a_virq_set: assert property (v_irq_event |=> v_irq_flag)
    else $error("vertical edge did not set flag");

endmodule : spg_sync_gen

// *** tb/spg_sync_source.sv ***
// Incoming sync source model: periodic active-high pulses while enabled
`timescale 1ns/1ps
module spg_sync_source #(
  parameter int PERIOD_CLKS = 400,
  parameter int HIGH_CLKS = 60
) (
  input wire logic ref_clk,
  input wire logic enable,
  output logic sync_line
);
  int cnt = 0;

  // Line idles low when the source is off, as a silent cable would
  always_ff @(posedge ref_clk) begin
    cnt <= (cnt == PERIOD_CLKS - 1) ? 0 : cnt + 1;
    sync_line <= enable && (cnt < HIGH_CLKS);
  end
endmodule : spg_sync_source

// *** tb/sync_pulse_generator_test.sv ***
// Self-checking bench of the sync pulse generator over APB and sync pins
`timescale 1ns/1ps
module sync_pulse_generator_test;
  import spg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  spg_apb_req_t apb_req = '0;
  spg_apb_rsp_t apb_rsp;
  logic src_en = 1'b0;
  logic h_src;
  logic v_src;
  logic green_src = 1'b0;
  logic sep_src = 1'b0;
  spg_meas_t meas_in = 6'h2a;
  logic v_irq_flag;
  spg_sync_out_t sync_out;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int hi;
  int lo;
  logic [31:0] rd;
  logic err;
  logic [7:0] idx_tab[4] = '{IDX_MODE_DETECT_CONTROL, IDX_HVGEN, IDX_CPGEN, IDX_HFL};
  logic [7:0] mask_tab[4] = '{MODE_DETECT_CONTROL_MASK, HVGEN_MASK, CPGEN_MASK, HFL_MASK};
  logic [7:0] hfh_tab[2] = '{8'h02, 8'h0a};
  logic [7:0] hfl_tab[2] = '{8'h83, 8'h1f};
  int hi_t[2] = '{5, 33};
  int lo_t[2] = '{5, 7};

  always #2 ref_clk = ~ref_clk;

  spg_sync_source #(.PERIOD_CLKS(400), .HIGH_CLKS(60)) h_source (
    .ref_clk(ref_clk), .enable(src_en), .sync_line(h_src));
  spg_sync_source #(.PERIOD_CLKS(1000), .HIGH_CLKS(200)) v_source (
    .ref_clk(ref_clk), .enable(src_en), .sync_line(v_src));

  spg_sync_gen DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .h_sync_input(h_src),
    .v_sync_input(v_src),
    .green_sync_input(green_src),
    .sep_v_sync_input(sep_src),
    .meas(meas_in),
    .v_irq_flag(v_irq_flag),
    .sync_out(sync_out)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic inr(input int x, input int lo_b, input int hi_b);
    check({31'h0, x >= lo_b && x <= hi_b}, 32'h1);
  endtask : inr

  // Setup then access phase; data and response taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= {2'h0, idx, ADDR_LSBS};
    apb_req.pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    @(posedge ref_clk);
    // Ends once pready is high; only the bench timeout ends a stall
    while (apb_rsp.pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge ref_clk);
  endtask : apb

  // Count active cycles over exactly two free-running frames
  task automatic duty(input int b);
    hi = 0;
    repeat (800) @(posedge ref_clk);
    repeat (1250) begin
      @(posedge ref_clk);
      hi += (sync_out[b] === 1'b1);
    end
  endtask : duty

  // Settle past any config change, then time one active and one idle phase
  task automatic measure(input int b, input logic act);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    repeat (1500) @(posedge ref_clk);
    while (sync_out[b] === act && n < 3000) begin
      n++;
      @(posedge ref_clk);
    end
    while (sync_out[b] !== act && n < 6000) begin
      n++;
      @(posedge ref_clk);
    end
    while (sync_out[b] === act && hi < 3000) begin
      hi++;
      @(posedge ref_clk);
    end
    while (sync_out[b] !== act && lo < 3000) begin
      lo++;
      @(posedge ref_clk);
    end
  endtask : measure

  task automatic level(input int b, input logic v);
    int bad;
    bad = 0;
    repeat (800) @(posedge ref_clk);
    repeat (1000) begin
      @(posedge ref_clk);
      bad += (sync_out[b] !== v);
    end
    check(bad, 0);
  endtask : level

  task automatic porch(input logic exp);
    int n;
    n = 0;
    repeat (800) @(posedge ref_clk);
    while (sync_out.clamp_output !== 1'b0 && n < 500) begin
      n++;
      @(posedge ref_clk);
    end
    while (sync_out.clamp_output !== 1'b1 && n < 1000) begin
      n++;
      @(posedge ref_clk);
    end
    check({31'h0, sync_out.h_sync_output}, {31'h0, exp});
  endtask : porch

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, idx_tab[i], 8'h00);
      check(rd, 32'h0);
      apb(1'b1, idx_tab[i], 8'hff);
      apb(1'b0, idx_tab[i], 8'h00);
      check(rd, {24'h0, mask_tab[i]});
      apb(1'b1, idx_tab[i], 8'h00);
    end
    apb(1'b0, 8'h10, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, IDX_MODE_DETECT_FLAGS, 8'h00);
    check(rd, 32'h2a);
    meas_in <= 6'h15;
    apb(1'b0, IDX_MODE_DETECT_FLAGS, 8'h00);
    check(rd, 32'h15);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, IDX_HFH, hfh_tab[i]);
      apb(1'b1, IDX_HFL, hfl_tab[i]);
      measure(3, 1'b1);
      inr(hi, 20 * hi_t[i], 21 * hi_t[i]);
      inr(lo, 20 * lo_t[i], 21 * lo_t[i]);
    end
    apb(1'b1, IDX_HFH, 8'h02);
    apb(1'b1, IDX_HFL, 8'h83);
    apb(1'b1, IDX_HVGEN, 8'h40);
    measure(3, 1'b0);
    inr(hi, 100, 105);
    apb(1'b1, IDX_VFL, 8'h30);
    apb(1'b1, IDX_HVGEN, 8'h04);
    measure(2, 1'b0);
    inr(hi, 400, 420);
    inr(lo, 200, 210);
    $display("test free run done");
    apb(1'b1, IDX_HVGEN, 8'h33);
    level(3, 1'b0);
    level(2, 1'b0);
    apb(1'b1, IDX_MODE_DETECT_FLAGS, 8'h40);
    apb(1'b0, IDX_MODE_DETECT_FLAGS, 8'h00);
    check({31'h0, rd[MODE_DETECT_FLAGS_VIRQ]}, 32'h0);
    src_en <= 1'b1;
    measure(3, 1'b1);
    inr(hi, 40, 85);
    inr(lo, 310, 360);
    apb(1'b0, IDX_MODE_DETECT_FLAGS, 8'h00);
    check({31'h0, rd[MODE_DETECT_FLAGS_VIRQ]}, 32'h1);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h02);
    level(3, 1'b0);
    green_src <= 1'b1;
    level(3, 1'b1);
    green_src <= 1'b0;
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h01);
    level(2, 1'b0);
    sep_src <= 1'b1;
    level(2, 1'b1);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h05);
    apb(1'b1, IDX_MODE_DETECT_FLAGS, 8'h40);
    apb(1'b0, IDX_MODE_DETECT_FLAGS, 8'h00);
    check({31'h0, rd[MODE_DETECT_FLAGS_VIRQ]}, 32'h0);
    sep_src <= 1'b0;
    repeat (50) @(posedge ref_clk);
    apb(1'b0, IDX_MODE_DETECT_FLAGS, 8'h00);
    check({31'h0, rd[MODE_DETECT_FLAGS_VIRQ]}, 32'h1);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h04);
    src_en <= 1'b0;
    apb(1'b1, IDX_HVGEN, 8'h11);
    measure(3, 1'b1);
    inr(hi, 100, 105);
    measure(2, 1'b1);
    inr(hi, 400, 420);
    $display("test follow and insert done");
    apb(1'b1, IDX_HVGEN, 8'h00);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h40);
    apb(1'b1, IDX_CPGEN, 8'h08);
    measure(1, 1'b1);
    inr(hi, 180, 189);
    porch(1'b1);
    apb(1'b1, IDX_CPGEN, 8'h48);
    porch(1'b0);
    apb(1'b1, IDX_CPGEN, 8'h88);
    measure(1, 1'b0);
    inr(hi, 180, 189);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h00);
    level(1, 1'b1);
    apb(1'b1, IDX_CPGEN, 8'h00);
    level(1, 1'b0);
    $display("test clamp done");
    level(0, 1'b0);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h20);
    level(0, 1'b1);
    apb(1'b1, IDX_CPGEN, {6'h00, PAT_BLACK});
    level(0, 1'b0);
    // Period 10 ticks, 3 lines: 12 of 30 ticks per frame on the grid
    apb(1'b1, IDX_CPGEN, {6'h00, PAT_HATCH});
    duty(0);
    inr(hi, 480, 504);
    apb(1'b1, IDX_CPGEN, {6'h00, PAT_INV_HATCH});
    duty(0);
    inr(hi, 746, 770);
    apb(1'b1, IDX_CPGEN, {6'h00, PAT_WHITE});
    apb(1'b1, IDX_HVGEN, 8'h33);
    level(0, 1'b0);
    apb(1'b1, IDX_HVGEN, 8'h00);
    apb(1'b1, IDX_MODE_DETECT_CONTROL, 8'h80);
    level(3, 1'b0);
    level(2, 1'b0);
    $display("test pattern and suspend done");
    conclude();
  end
endmodule : sync_pulse_generator_test
